// File: rtl/sct_top.v
/*
 * Clock source choice, start-up count, PLL clock enables, lock, pins, RC tuning.
 * Assumes all ticks are synchronous to clk_sys; derived clocks are enables.
 */
`timescale 1ns/1ps
`include "sct_defines.vh"
module sct_top (
    input  wire        clk_sys,
    input  wire        srst,
    input  wire [1:0]  oscillator_group_select,
    input  wire [1:0]  primary_osc_mode_select,
    input  wire        clock_out_pin_pin_function_select,
    input  wire        frc_high_range_select,
    input  wire        failsafe_monitor_enable,
    input  wire        clock_fail_detect,
    input  wire        wake_from_sleep,
    input  wire        clock_in_pin,
    input  wire        frc_tick,
    input  wire        pll_tick,
    input  wire [5:0]  pwm_roll_count,
    output reg         pwm_clk_en_q,
    output reg         adc_clk_en_q,
    output reg         pll_div8_en_q,
    output reg         instruction_cycle_clock_q,
    output reg         clock_out_pin_o_q,
    output reg         clock_out_pin_oe_q,
    output reg         clock_out_pin_gpio_release_q,
    output reg         osc_feedback_en_q,
    output reg         frc_power_en_q,
    output reg         frc_high_range_q,
    output reg  [3:0]  frc_tune_field_q,
    output reg         osc_released_q,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    reg  [1:0]  cfg_mode_q;
    reg         cfg_pinf_q;
    reg  [2:0]  cur_q;
    reg  [2:0]  nosc_q;
    reg         fail_q;
    reg         osw_q;
    reg         tseq_q;
    reg         prcd_q;
    reg  [1:0]  key_st_q;
    reg         lo_arm_q;
    reg         hi_arm_q;
    reg         pin_prev_q;
    reg  [9:0]  st_cnt_q;
    reg         st_done_q;
    reg  [3:0]  div_q;
    reg         div8_half_q;
    reg         osc_half_q;
    reg  [6:0]  lock_cnt_q;
    reg         lock_raw_q;
    reg         lock_s1_q;
    reg         lock_s2_q;
    reg  [14:0] lfsr_q;
    reg         roll3_prev_q;
    reg         aw_hold_q;
    reg         w_hold_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg  [31:0] ctrl_rd;
    reg  [31:0] rd_mux;
    reg         rd_ok;
    wire [3:0]  mem_rd;
    wire [31:0] mem_all;

    wire pri_act  = cur_q[1];
    wire pll_on   = cur_q[0];
    wire xtal_act = pri_act & (cfg_mode_q == `SCT_MODE_XTAL);
    wire ext_act  = pri_act & (cfg_mode_q == `SCT_MODE_EXT);

    wire pin_rise = clock_in_pin & ~pin_prev_q;
    wire raw_tick = pri_act ? pin_rise : frc_tick;
    wire osc_ok   = st_done_q | ~xtal_act;
    wire osc_tick = raw_tick & osc_ok;
    wire pll_g    = pll_tick & osc_ok & pll_on;

    wire adc_tick  = pll_g & ((div_q & `SCT_ADC_MASK) == `SCT_ADC_MASK);
    wire div8_tick = pll_g & ((div_q & `SCT_DIV8_MASK) == `SCT_DIV8_MASK);
    wire half_tick = osc_tick & osc_half_q;
    wire mux_pll   = div8_tick & div8_half_q;
    wire instr_tick = pll_on ? mux_pll : half_tick;
    wire [6:0] lock_inc = lock_cnt_q + {6'h0, pll_g};

    wire wr_go  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire wr_ctl = wr_go & (awaddr_q == `SCT_OFF_CTRL);
    wire wr_tun = wr_go & (awaddr_q == `SCT_OFF_TUNE);
    wire wr_seq = wr_go & (awaddr_q == `SCT_OFF_SEQ);
    wire wr_key = wr_go & (awaddr_q == `SCT_OFF_KEY);
    wire wr_hit = wr_ctl | wr_tun | wr_seq | wr_key |
                  (awaddr_q == `SCT_OFF_STAT);
    wire [7:0] key_b = wdata_q[7:0];

    // Entry 0 is the primary tune value; entries 1 to 7 are the sequence.
    wire [7:0] mem_we = {{2{wr_seq & wstrb_q[3]}}, {2{wr_seq & wstrb_q[2]}},
                         {2{wr_seq & wstrb_q[1]}}, wr_seq & wstrb_q[0],
                         wr_tun & wstrb_q[0]};
    wire [31:0] mem_wd = wr_tun ? {28'h0, wdata_q[`SCT_F_TUNE]} : wdata_q;

    sct_tune_mem u_mem (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .wr_en     (mem_we),
        .wr_data   (mem_wd),
        .rd_idx    (pwm_roll_count[5:3]),
        .rd_data_q (mem_rd),
        .all_q     (mem_all)
    );

    always @(posedge clk_sys) begin
        if (srst) begin
            cfg_mode_q <= primary_osc_mode_select;
            cfg_pinf_q <= clock_out_pin_pin_function_select;
            cur_q      <= {1'b0, oscillator_group_select};
            nosc_q     <= {1'b0, oscillator_group_select};
            fail_q     <= 1'b0;
            osw_q      <= 1'b0;
            tseq_q     <= 1'b0;
            prcd_q     <= 1'b0;
        end else begin
            if (wr_ctl & lo_arm_q & wstrb_q[0]) begin
                tseq_q <= wdata_q[`SCT_B_TSEQ];
                prcd_q <= wdata_q[`SCT_B_PRCD];
                osw_q  <= wdata_q[`SCT_B_OSW];
                if (!wdata_q[`SCT_B_FAIL]) begin
                    fail_q <= 1'b0;
                end
            end
            if (wr_ctl & hi_arm_q & wstrb_q[1]) begin
                nosc_q <= wdata_q[`SCT_F_NOSC];
            end
            // A switch moves between groups only; PLL use stays as configured.
            if (osw_q) begin
                cur_q  <= {1'b0, nosc_q[1], cur_q[0]};
                osw_q  <= 1'b0;
            end
            // Failure handling comes last so that it wins over software.
            if (clock_fail_detect & failsafe_monitor_enable) begin
                cur_q  <= {1'b0, 1'b0, cur_q[0]};
                fail_q <= 1'b1;
                osw_q  <= 1'b0;
            end
        end
    end

    // Unlock keys must arrive back to back; any other write disarms.
    always @(posedge clk_sys) begin
        if (srst) begin
            key_st_q <= `SCT_KS_IDLE;
            lo_arm_q <= 1'b0;
            hi_arm_q <= 1'b0;
        end else if (wr_go) begin
            key_st_q <= `SCT_KS_IDLE;
            lo_arm_q <= 1'b0;
            hi_arm_q <= 1'b0;
            if (wr_key & wstrb_q[0]) begin
                case (key_st_q)
                    `SCT_KS_LO1: begin
                        lo_arm_q <= (key_b == `SCT_KEY_LO2);
                    end
                    `SCT_KS_HI1: begin
                        hi_arm_q <= (key_b == `SCT_KEY_HI2);
                    end
                    default: begin
                        key_st_q <= `SCT_KS_IDLE;
                    end
                endcase
                if (key_b == `SCT_KEY_LO1) begin
                    key_st_q <= `SCT_KS_LO1;
                end else if (key_b == `SCT_KEY_HI1) begin
                    key_st_q <= `SCT_KS_HI1;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            pin_prev_q  <= clock_in_pin;
            st_cnt_q    <= 10'h000;
            st_done_q   <= 1'b0;
            div_q       <= 4'h0;
            div8_half_q <= 1'b0;
            osc_half_q  <= 1'b0;
            lock_cnt_q  <= 7'h00;
            lock_raw_q  <= 1'b0;
        end else begin
            pin_prev_q <= clock_in_pin;
            if (wake_from_sleep) begin
                st_cnt_q  <= 10'h000;
                st_done_q <= 1'b0;
            end else if (xtal_act & pin_rise & ~st_done_q) begin
                st_cnt_q <= st_cnt_q + 10'h001;
                if (st_cnt_q == `SCT_START_LAST) begin
                    st_done_q <= 1'b1;
                end
            end
            if (pll_g) begin
                div_q <= div_q + 4'h1;
            end
            if (div8_tick) begin
                div8_half_q <= ~div8_half_q;
            end
            if (osc_tick) begin
                osc_half_q <= ~osc_half_q;
            end
            // Lock means exactly 32 PLL edges fell in one oscillator period.
            if (!pll_on) begin
                lock_cnt_q <= 7'h00;
                lock_raw_q <= 1'b0;
            end else if (osc_tick) begin
                lock_cnt_q <= 7'h00;
                lock_raw_q <= (lock_inc == {1'b0, `SCT_PLL_MULT});
            end else if (lock_cnt_q[6] == 1'b0) begin
                lock_cnt_q <= lock_inc;
            end
        end
    end

    // Lock crosses into the instruction clock before it is shown.
    always @(posedge clk_sys) begin
        if (srst) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else if (instr_tick) begin
            lock_s1_q <= lock_raw_q;
            lock_s2_q <= lock_s1_q;
        end
    end

    // Pseudo-random dither steps each time rollover bit three changes.
    always @(posedge clk_sys) begin
        if (srst) begin
            lfsr_q       <= `SCT_LFSR_SEED;
            roll3_prev_q <= 1'b0;
        end else begin
            roll3_prev_q <= pwm_roll_count[3];
            if (pwm_roll_count[3] != roll3_prev_q) begin
                lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
            end
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            pwm_clk_en_q              <= 1'b0;
            adc_clk_en_q              <= 1'b0;
            pll_div8_en_q             <= 1'b0;
            instruction_cycle_clock_q <= 1'b0;
            clock_out_pin_o_q         <= 1'b0;
            clock_out_pin_oe_q        <= 1'b0;
            clock_out_pin_gpio_release_q       <= 1'b0;
            osc_feedback_en_q         <= 1'b0;
            frc_power_en_q            <= 1'b0;
            frc_high_range_q          <= 1'b0;
            frc_tune_field_q          <= 4'h0;
            osc_released_q            <= 1'b0;
        end else begin
            pwm_clk_en_q              <= pll_g;
            adc_clk_en_q              <= adc_tick;
            pll_div8_en_q             <= div8_tick;
            instruction_cycle_clock_q <= instr_tick;
            osc_released_q            <= osc_ok;
            osc_feedback_en_q         <= xtal_act;
            if (xtal_act) begin
                clock_out_pin_oe_q  <= 1'b1;
                clock_out_pin_o_q   <= clock_in_pin;
                clock_out_pin_gpio_release_q <= 1'b0;
            end else if (cfg_pinf_q) begin
                clock_out_pin_oe_q  <= 1'b1;
                clock_out_pin_o_q   <= osc_half_q;
                clock_out_pin_gpio_release_q <= 1'b0;
            end else begin
                clock_out_pin_oe_q  <= 1'b0;
                clock_out_pin_o_q   <= 1'b0;
                clock_out_pin_gpio_release_q <= 1'b1;
            end
            frc_power_en_q   <= ~(xtal_act | ext_act) | fail_q;
            frc_high_range_q <= frc_high_range_select;
            if (prcd_q) begin
                frc_tune_field_q <= lfsr_q[3:0];
            end else if (tseq_q) begin
                frc_tune_field_q <= mem_rd;
            end else begin
                frc_tune_field_q <= mem_all[`SCT_F_TUNE];
            end
        end
    end

    always @* begin
        ctrl_rd              = 32'h0;
        ctrl_rd[`SCT_F_CUR]  = cur_q;
        ctrl_rd[`SCT_F_NOSC] = nosc_q;
        ctrl_rd[`SCT_B_LOCK] = lock_s2_q;
        ctrl_rd[`SCT_B_FAIL] = fail_q;
        ctrl_rd[`SCT_B_TSEQ] = tseq_q;
        ctrl_rd[`SCT_B_PRCD] = prcd_q;
        ctrl_rd[`SCT_B_OSW]  = osw_q;
        rd_ok  = 1'b1;
        rd_mux = 32'h0;
        case (s_axi_araddr)
            `SCT_OFF_CTRL: begin
                rd_mux = ctrl_rd;
            end
            `SCT_OFF_TUNE: begin
                rd_mux = {28'h0, mem_all[`SCT_F_TUNE]};
            end
            `SCT_OFF_SEQ: begin
                rd_mux = {mem_all[31:4], 4'h0};
            end
            `SCT_OFF_KEY: begin
                rd_mux = {30'h0, hi_arm_q, lo_arm_q};
            end
            `SCT_OFF_STAT: begin
                rd_mux = {20'h0, frc_tune_field_q, 3'h0, frc_power_en_q,
                          ext_act, xtal_act, pll_on, osc_ok};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // AXI4-Lite slave: address and data are taken in either order.
    always @(posedge clk_sys) begin
        if (srst) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SCT_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `SCT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_hold_q     <= 1'b0;
                w_hold_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_ok ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// File: rtl/sct_tune_mem.v
/*
 * Eight 4-bit tune entries: per-entry writes, registered indexed read, readback.
 * Assumes clk_sys and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module sct_tune_mem (
    input  wire        clk_sys,
    input  wire        srst,
    input  wire [7:0]  wr_en,
    input  wire [31:0] wr_data,
    input  wire [2:0]  rd_idx,
    output reg  [3:0]  rd_data_q,
    output wire [31:0] all_q
);
    reg [3:0] ent_q [0:7];

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : ent
            always @(posedge clk_sys) begin
                if (srst) begin
                    ent_q[g] <= 4'h0;
                end else if (wr_en[g]) begin
                    ent_q[g] <= wr_data[4*g+3:4*g];
                end
            end
            assign all_q[4*g+3:4*g] = ent_q[g];
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (srst) begin
            rd_data_q <= 4'h0;
        end else begin
            rd_data_q <= ent_q[rd_idx];
        end
    end
endmodule

// File: shared/sct_defines.vh
/*
 * Constants of the clock source and tuning block: offsets, fields, codes, keys.
 * Assumes one 25 MHz clock and a 32-bit AXI4-Lite register bus.
 */
// Notes on behaviour
// - PLL output is 32 times its input; it clocks the PWM.
// - ADC clock is PLL output over two.
// - PLL output over eight feeds the instruction clock mux.
// - Instruction clock: PLL over 16, or oscillator over 2.
// - Source comes from three configuration settings at reset.
// - Group 11/01/10/00: primary+PLL, RC+PLL, primary, RC.
// - Mode 10 crystal, 00 external clock, 11 internal RC.
// - Pin select: clock or I/O; crystal always drives oscillator.
// - Oscillator held until 1024 cycles on a 10-bit counter.
// - Start-up count in crystal mode only; restarts at reset, wake.
// - PLL gain fixed at 32.
// - Lock flag follows PLL lock, read-only in control.
// - External clock with output: pin carries oscillator over two.
// - External clock with I/O: pin released, feedback off.
// - RC powered unless external or crystal, or after failure.
// - Range select picks RC low or high range.
// - Tune from tune register, or sequence when enabled.
// - Tune 0111 at high range gives top RC frequency.
// - Sequencing and random dither change clock per PWM cycle.
// - Sequencing indexes eight tunes by rollover bits 5 to 3.
// - Random tune: low nibble of 15-bit LFSR, stepped on bit 3 toggle.
// - Failure: RC into current osc, fail flag set, switch cleared.
`ifndef SCT_DEFINES_VH
`define SCT_DEFINES_VH

`define SCT_OFF_CTRL     8'h00
`define SCT_OFF_TUNE     8'h04
`define SCT_OFF_SEQ      8'h08
`define SCT_OFF_KEY      8'h0C
`define SCT_OFF_STAT     8'h10

`define SCT_F_CUR        14:12
`define SCT_F_NOSC       10:8
`define SCT_B_LOCK       5
`define SCT_B_FAIL       3
`define SCT_B_TSEQ       2
`define SCT_B_PRCD       1
`define SCT_B_OSW        0
`define SCT_F_TUNE       3:0

`define SCT_GRP_PRI_PLL  2'b11
`define SCT_GRP_RC_PLL   2'b01
`define SCT_GRP_PRI      2'b10
`define SCT_GRP_RC       2'b00
`define SCT_MODE_XTAL    2'b10
`define SCT_MODE_EXT     2'b00
`define SCT_MODE_RC      2'b11

`define SCT_PLL_MULT     6'h20
`define SCT_ADC_MASK     4'h1
`define SCT_DIV8_MASK    4'h7
`define SCT_DIV16_MASK   4'hF
`define SCT_START_LAST   10'h3FF

`define SCT_KEY_LO1      8'h46
`define SCT_KEY_LO2      8'h57
`define SCT_KEY_HI1      8'h78
`define SCT_KEY_HI2      8'h9A
`define SCT_KS_IDLE      2'h0
`define SCT_KS_LO1       2'h1
`define SCT_KS_HI1       2'h2

`define SCT_LFSR_SEED    15'h7FFF
`define SCT_RESP_OKAY    2'h0
`define SCT_RESP_SLVERR  2'h2

`endif

// File: sim/sct_osc_model.sv
/* Far side: oscillator pin of period 32 cycles, PLL and RC ticks.
   Assumes clk_sys steps it. */
`timescale 1ns/1ps
module sct_osc_model (
    input  wire clk_sys,
    input  wire pll_slow,
    output reg  clock_in_pin,
    output reg  pll_tick,
    output reg  frc_tick
);
    reg [3:0] cnt_q;
    initial begin
        cnt_q = 4'h0;
        clock_in_pin = 1'b0;
        pll_tick = 1'b0;
        frc_tick = 1'b1;
    end
    always @(posedge clk_sys) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'hF)
            clock_in_pin <= ~clock_in_pin;
        // Thirty-two ticks per pin period keep lock; halving them loses it.
        pll_tick <= pll_slow ? ~pll_tick : 1'b1;
    end
endmodule

// File: sim/sct_top_checker.sv
/* Assertions on the ports of sct_top, bound below.
   Assumes configuration is stable in reset. */
`timescale 1ns/1ps
`include "sct_defines.vh"
module sct_top_checker (
    input wire       clk_sys,
    input wire       srst,
    input wire [1:0] oscillator_group_select,
    input wire [1:0] primary_osc_mode_select,
    input wire       frc_high_range_select,
    input wire       wake_from_sleep,
    input wire       clock_in_pin,
    input wire       pll_tick,
    input wire       pwm_clk_en_q,
    input wire       adc_clk_en_q,
    input wire       clock_out_pin_oe_q,
    input wire       clock_out_pin_gpio_release_q,
    input wire       osc_feedback_en_q,
    input wire       frc_power_en_q,
    input wire       frc_high_range_q,
    input wire       osc_released_q
);
    reg  [1:0]  grp_q, mode_q;
    reg  [10:0] edges_q;
    reg         pin_q;
    wire        xtal = grp_q[1] && mode_q == `SCT_MODE_XTAL;
    wire        ext  = grp_q[1] && mode_q == `SCT_MODE_EXT;
    // Counts oscillator rising edges since reset or wake-up, saturating.
    always @(posedge clk_sys) begin
        pin_q <= clock_in_pin;
        if (srst) begin
            grp_q <= oscillator_group_select;
            mode_q <= primary_osc_mode_select;
        end
        if (srst || wake_from_sleep)
            edges_q <= 11'h000;
        else if (clock_in_pin && !pin_q && edges_q != 11'h7FF)
            edges_q <= edges_q + 11'h001;
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    a_pwm_from_tick: assert property (pwm_clk_en_q |-> $past(pll_tick))
        else $error("PWM enable without PLL tick.");
    a_adc_half_rate: assert property (adc_clk_en_q |-> pwm_clk_en_q ##1 !adc_clk_en_q)
        else $error("ADC enable off half rate.");
    a_pin_exclusive: assert property (!(clock_out_pin_oe_q && clock_out_pin_gpio_release_q))
        else $error("Pin driven and released.");
    a_feedback_xtal: assert property (osc_feedback_en_q |-> xtal)
        else $error("Feedback on outside crystal mode.");
    a_frc_powered: assert property (!xtal && !ext |-> ##[0:3] frc_power_en_q)
        else $error("RC not powered.");
    a_range_follow: assert property (!$past(srst) && !$past(srst, 2) |->
        frc_high_range_q == $past(frc_high_range_select)) else $error("Range not followed.");
    a_startup_count: assert property ($rose(osc_released_q) && xtal |-> edges_q >= 11'h400)
        else $error("Oscillator released early.");
    a_release_other: assert property (!xtal |-> ##[0:3] osc_released_q)
        else $error("Oscillator held outside crystal mode.");
endmodule
bind sct_top sct_top_checker u_chk (.*);

// File: sim/tb.sv
/* Bench for sct_top: configurations, rates, lock, failure, tuning, dither.
   Assumes sct_osc_model as far side. */
`timescale 1ns/1ps
`include "sct_defines.vh"
module tb;
    localparam [29:0] CFGS = 30'h0F0CB9FC;
    reg         clk_sys, srst, clock_out_pin_pin_function_select, frc_high_range_select, pll_slow, d;
    reg         failsafe_monitor_enable, clock_fail_detect, wake_from_sleep;
    reg  [1:0]  oscillator_group_select, primary_osc_mode_select, rr;
    reg  [5:0]  pwm_roll_count;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [3:0]  s_axi_wstrb, tun;
    reg  [31:0] s_axi_wdata, rd, seq;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [14:0] lf;
    reg  [8:0]  ev;
    wire        clock_in_pin, frc_tick, pll_tick, pwm_clk_en_q, adc_clk_en_q, pll_div8_en_q;
    wire        instruction_cycle_clock_q, clock_out_pin_o_q, clock_out_pin_oe_q, clock_out_pin_gpio_release_q;
    wire        osc_feedback_en_q, frc_power_en_q, frc_high_range_q, osc_released_q;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [3:0]  frc_tune_field_q;
    wire [31:0] s_axi_rdata;
    wire [3:0]  pins = {clock_out_pin_oe_q, clock_out_pin_gpio_release_q, osc_feedback_en_q, frc_power_en_q};
    integer     failures, tests_run, seed, i, k, n, c0, c1, c2, c3;

    sct_top uut (.*);
    sct_osc_model u_osc (.clk_sys(clk_sys), .pll_slow(pll_slow), .clock_in_pin(clock_in_pin),
                         .pll_tick(pll_tick), .frc_tick(frc_tick));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        frc_high_range_select <= $random(seed);

    function [8:0] exp_cfg(input [4:0] c);
        reg x, e;
        begin
            x = c[4] && c[2:1] == `SCT_MODE_XTAL;
            e = c[4] && c[2:1] == `SCT_MODE_EXT;
            exp_cfg = {x || c[0], !(x || c[0]), x, !(x || e), !(x || e), e, x, c[3], 1'b1};
        end
    endfunction
    task give_verdict;
        begin
            if (failures == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("BAD %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task hang;
        begin
            if (!d) begin
                failures = failures + 1;
                give_verdict;
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_sys);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_bready <= w;
            s_axi_arvalid <= !w;
            s_axi_rready <= !w;
            d = 1'b0;
            for (n = 0; n < 60 && !d; n = n + 1) begin
                @(posedge clk_sys);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_bvalid || s_axi_rvalid) begin
                    s_axi_bready <= 1'b0;
                    s_axi_rready <= 1'b0;
                    rd = s_axi_rdata;
                    rr = s_axi_rresp;
                    d = 1'b1;
                end
            end
            hang;
        end
    endtask
    task ctl(input [31:0] v);
        begin
            bus(1'b1, `SCT_OFF_KEY, `SCT_KEY_LO1);
            bus(1'b1, `SCT_OFF_KEY, `SCT_KEY_LO2);
            bus(1'b1, `SCT_OFF_CTRL, v);
        end
    endtask
    task rst(input [4:0] c);
        begin
            {oscillator_group_select, primary_osc_mode_select, clock_out_pin_pin_function_select} <= c;
            srst <= 1'b1;
            repeat (6) @(posedge clk_sys);
            srst <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rates;
        begin
            c0 = 0;
            c1 = 0;
            c2 = 0;
            c3 = 0;
            repeat (320) begin
                @(posedge clk_sys);
                c0 = c0 + pwm_clk_en_q;
                c1 = c1 + adc_clk_en_q;
                c2 = c2 + pll_div8_en_q;
                c3 = c3 + instruction_cycle_clock_q;
            end
        end
    endtask

    initial begin
        seed = 32'hC7781A19;
        failures = 0;
        tests_run = 0;
        {srst, pll_slow, failsafe_monitor_enable, clock_fail_detect, wake_from_sleep} = 5'h10;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h000000000000F;
        {oscillator_group_select, primary_osc_mode_select, clock_out_pin_pin_function_select} = 5'h00;
        pwm_roll_count = 6'h00;
        for (i = 0; i < 6; i = i + 1) begin
            rst(CFGS[5*i +: 5]);
            ev = exp_cfg(CFGS[5*i +: 5]);
            d = 1'b0;
            for (k = 0; k < 40000 && !d; k = k + 1) begin
                @(posedge clk_sys);
                d = osc_released_q;
            end
            hang;
            repeat (200) @(posedge clk_sys);
            bus(1'b0, `SCT_OFF_STAT, 32'h0);
            chk("status", rd[4:0], ev[4:0]);
            chk("pins", pins, ev[8:5]);
            if (!oscillator_group_select[1]) begin
                rates;
                chk("icyc", c3, oscillator_group_select[0] ? 20 : 160);
            end
            if (oscillator_group_select == `SCT_GRP_RC_PLL) begin
                chk("pwm", c0, 320);
                chk("adc", c1, 160);
                chk("div8", c2, 40);
            end
            if (i == 0) begin
                bus(1'b0, `SCT_OFF_CTRL, 32'h0);
                chk("lock", {rd[14:12], rd[5]}, 4'h7);
                pll_slow <= 1'b1;
                repeat (400) @(posedge clk_sys);
                bus(1'b0, `SCT_OFF_CTRL, 32'h0);
                chk("unlock", rd[5], 1'b0);
                {pll_slow, failsafe_monitor_enable, clock_fail_detect} <= 3'h3;
                @(posedge clk_sys);
                clock_fail_detect <= 1'b0;
                repeat (4) @(posedge clk_sys);
                bus(1'b0, `SCT_OFF_CTRL, 32'h0);
                chk("fail", {rd[14:12], rd[3], rd[0], frc_power_en_q}, 6'h0D);
                failsafe_monitor_enable <= 1'b0;
            end
        end
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", rr, `SCT_RESP_SLVERR);
        tun = $random(seed);
        seq = $random(seed);
        bus(1'b1, `SCT_OFF_TUNE, {28'h0, tun});
        bus(1'b1, `SCT_OFF_SEQ, seq);
        bus(1'b1, `SCT_OFF_CTRL, 32'h4);
        pwm_roll_count <= 6'h38;
        repeat (4) @(posedge clk_sys);
        chk("tune", frc_tune_field_q, tun);
        ctl(32'h4);
        for (k = 0; k < 8; k = k + 1) begin
            pwm_roll_count <= {k[2:0], 3'h5};
            repeat (4) @(posedge clk_sys);
            chk("seq", frc_tune_field_q, k ? seq[4*k +: 4] : tun);
        end
        pwm_roll_count <= 6'h00;
        rst(5'h07);
        ctl(32'h2);
        lf = `SCT_LFSR_SEED;
        for (k = 0; k < 5; k = k + 1) begin
            repeat (4) @(posedge clk_sys);
            chk("dither", frc_tune_field_q, lf[3:0]);
            pwm_roll_count[3] <= ~pwm_roll_count[3];
            lf = {lf[13:0], lf[14] ^ lf[13]};
        end
        give_verdict;
    end
endmodule
